// file: bench/csf_ctrl_model.sv
// machine controller model that latches the routed control outputs
`timescale 1ns/1ps
`default_nettype none
module csf_ctrl_model (
  input wire logic sys_clk,
  input wire logic [3:0] ctrl_out,
  output logic [3:0] seen
);
  // high means the routed signal is on, low means off
  always_ff @(posedge sys_clk) begin
    seen <= ctrl_out;
  end
endmodule : csf_ctrl_model
`default_nettype wire

// file: bench/csf_top_bench.sv
// self-checking bench for the cutter status flag generator
`timescale 1ns/1ps
`default_nettype none
`include "csf_defines.svh"
module csf_top_bench
  import csf_pkg::*;
;
  logic sys_clk = 0;
  logic nrst = 0;
  csf_state_t st = '0;
  logic run_pin = 0;
  logic enable_pin = 1;
  logic clear_pin = 0;
  logic [`CSF_AW-1:0] addr = '0;
  logic [`CSF_DW-1:0] wdata = '0;
  logic wr = 0;
  logic rd = 0;
  logic [`CSF_DW-1:0] rdata, flags, got;
  logic [`CSF_NOUT-1:0] hw_out, seen;
  logic [15:0] lim [0:31];
  logic [31:0] seed = 32'd91559;
  int err_count = 0;
  int tests_run = 0;
  // comparator flags, the error flag and the unused slots 17 to 21 and 26 to 31, which must read low
  localparam logic [31:0] MASK = 32'hfffe5814;

  always #12.5 sys_clk = ~sys_clk;

  csf_top i_csf_top (.sys_clk(sys_clk), .nrst(nrst), .st(st), .run_pin(run_pin),
    .enable_pin(enable_pin), .clear_pin(clear_pin), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .flags(flags), .hw_out(hw_out));
  csf_ctrl_model i_csf_ctrl_model (.sys_clk(sys_clk), .ctrl_out(hw_out), .seen(seen));

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd

  // corner pass puts every value right on its limit
  function automatic logic [15:0] val(input int i);
    return (i == 0) ? 16'h0100 : 16'(rnd() >> 8);
  endfunction : val

  function automatic logic [16:0] mag(input logic signed [15:0] v);
    logic signed [16:0] w;
    w = v;
    return (w < 0) ? 17'(-w) : 17'(w);
  endfunction : mag

  function automatic logic [31:0] exp_cmp();
    logic [31:0] e;
    e = '0;
    e[2] = mag(st.cut_err) > lim[1];
    e[22] = mag(st.feed_err) > lim[2];
    e[24] = st.dan_val > lim[3];
    e[14] = mag(st.cut_corr) >= lim[4];
    e[23] = mag(st.feed_corr) >= lim[5];
    e[25] = mag(st.dan_corr) >= lim[6];
    e[11] = st.mst_speed > lim[7];
    e[12] = st.vm_freq > lim[8];
    e[4] = st.op_error;
    return e;
  endfunction : exp_cmp

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : step

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] a);
    tests_run++;
    if (a !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, a);
      err_count++;
    end
  endtask : chk

  // five cycles covers pin sync plus the sticky-flag latency
  task automatic fl(input int n, input logic e);
    step(5);
    chk($sformatf("flag %0d", n), {31'h0, e}, {31'h0, flags[n]});
  endtask : fl

  task automatic wreg(input logic [4:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1;
    lim[a] = d[15:0];
    step(1);
    wr <= 0;
    // idle edge, so a following strobe is not assigned twice in one step
    step(1);
  endtask : wreg

  task automatic rreg(input logic [4:0] a);
    addr <= a;
    rd <= 1;
    step(1);
    rd <= 0;
    got = rdata;
    step(1);
  endtask : rreg

  task automatic steps(input int n);
    repeat (n) begin
      st.mst_step <= 1;
      step(1);
      st.mst_step <= 0;
      step(1);
    end
  endtask : steps

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  initial begin
    #200000;
    $display("MISMATCH watchdog expected finish seen hang");
    err_count++;
    final_report();
  end

  initial begin
    logic [31:0] e;
    step(8);
    chk("flags in reset", 32'h0, flags);
    chk("hw_out in reset", 32'h0, {28'h0, hw_out});
    nrst <= 1;
    step(3);
    fl(10, 1);
    fl(1, 0);
    st.init_done <= 1;
    fl(1, 0);
    st.selftest_ok <= 1;
    fl(1, 1);
    $display("test ready done");
    wreg(20, {12'h0, 5'd24, 5'd11, 5'd4, 5'd2});
    for (int i = 0; i < 40; i++) begin
      for (int r = 1; r <= 8; r++) wreg(r[4:0], (i == 0) ? 32'h100 : rnd() >> 17);
      st.cut_err <= val(i);
      st.feed_err <= val(i);
      st.dan_val <= val(i);
      st.cut_corr <= val(i);
      st.feed_corr <= val(i);
      st.dan_corr <= val(i);
      st.mst_speed <= val(i);
      st.vm_freq <= val(i);
      st.op_error <= 1'(rnd() >> 31);
      step(3);
      e = exp_cmp();
      chk("flags", e & MASK, flags & MASK);
      chk("flags", e & MASK, flags & MASK);
      chk("hw_out", {28'h0, e[24], e[11], e[4], e[2]}, {28'h0, seen});
      rreg(0);
      chk("status", e & MASK, got & MASK);
    end
    wreg(0, 32'hffffffff);
    rreg(0);
    chk("status after write", e & MASK, got & MASK);
    rreg(21);
    chk("unmapped read", 32'h0, got);
    $display("test comparators done");
    st.homing_fin <= 1;
    step(1);
    st.homing_fin <= 0;
    fl(5, 1);
    st.jog_active <= 1;
    step(1);
    st.jog_active <= 0;
    fl(5, 0);
    st.homing_fin <= 1;
    step(1);
    st.homing_fin <= 0;
    fl(5, 1);
    enable_pin <= 0;
    fl(5, 0);
    enable_pin <= 1;
    $display("test homing done");
    st.cut_busy <= 1;
    run_pin <= 1;
    fl(6, 1);
    run_pin <= 0;
    fl(6, 1);
    st.cut_busy <= 0;
    st.roll_still <= 1;
    fl(6, 0);
    $display("test auto done");
    st.knife_pos <= 16'd600;
    st.sync_end <= 1;
    step(1);
    st.sync_end <= 0;
    fl(7, 0);
    wreg(12, 32'd500);
    st.knife_pos <= 16'd500;
    step(1);
    st.knife_pos <= 16'd600;
    fl(7, 1);
    st.sync_end <= 1;
    step(1);
    st.sync_end <= 0;
    fl(7, 0);
    fl(9, 0);
    st.teach_ok <= 1;
    step(1);
    st.teach_ok <= 0;
    fl(9, 1);
    $display("test cut pulse and teach done");
    wreg(9, 32'd3);
    st.mst_back <= 1;
    steps(3);
    fl(13, 0);
    steps(1);
    fl(13, 1);
    st.mst_back <= 0;
    steps(3);
    fl(13, 1);
    steps(1);
    fl(13, 0);
    st.mst_back <= 1;
    steps(4);
    fl(13, 1);
    clear_pin <= 1;
    fl(13, 0);
    clear_pin <= 0;
    $display("test reverse done");
    wreg(19, 32'd10);
    for (int k = 0; k < 4; k++) begin
      st.test_cut <= (k == 0);
      st.len_dev <= (k == 2) ? -16'sd11 : (k == 3) ? 16'sd10 : 16'sd5;
      st.cut_done <= 1;
      step(1);
      st.cut_done <= 0;
      st.test_cut <= 0;
      fl(16, k == 0 || k == 2);
    end
    $display("test waste done");
    wreg(10, 32'd100);
    wreg(11, 32'd200);
    st.knife_pos <= 16'd150;
    fl(3, 1);
    st.knife_pos <= 16'd300;
    fl(3, 0);
    // low bound above high bound wraps through zero
    wreg(10, 32'd700);
    fl(3, 0);
    st.knife_pos <= 16'd50;
    fl(3, 1);
    $display("test home window done");
    wreg(13, 32'd100);
    wreg(14, 32'd200);
    wreg(15, 32'd100);
    wreg(16, 32'd200);
    wreg(17, {29'h0, `CSF_THK_IN, 1'b1});
    fl(10, 0);
    fl(15, 0);
    st.knife_pos <= 16'd150;
    fl(10, 1);
    fl(15, 1);
    wreg(17, {29'h0, `CSF_THK_OUT, 1'b1});
    fl(15, 0);
    st.knife_pos <= 16'd300;
    fl(15, 1);
    fl(10, 0);
    wreg(17, {29'h0, `CSF_THK_OFF, 1'b1});
    fl(15, 0);
    $display("test mark and thickness windows done");
    wreg(18, 32'd3);
    for (int s = 1; s <= 3; s++) begin
      st.sheet_end <= 1;
      step(1);
      st.sheet_end <= 0;
      fl(8, s == 3);
    end
    st.mark_seen <= 1;
    step(1);
    st.mark_seen <= 0;
    fl(8, 0);
    $display("test missing mark done");
    nrst <= 0;
    step(2);
    chk("flags in mid-run reset", 32'h0, flags);
    chk("hw_out in mid-run reset", 32'h0, {28'h0, hw_out});
    nrst <= 1;
    step(3);
    fl(1, 1);
    fl(9, 0);
    $display("test mid-run reset done");
    final_report();
  end
endmodule : csf_top_bench
`default_nettype wire

// file: core/csf_mag_cmp.sv
// magnitude of a signed value against an unsigned limit
`timescale 1ns/1ps
`default_nettype none
module csf_mag_cmp (
  input wire logic signed [15:0] val,
  input wire logic [15:0] lim,
  output logic over,
  output logic reach
);
  // widened so that the most negative value has a magnitude
  wire logic signed [16:0] wide = {val[15], val};
  wire logic [16:0] mag = wide[16] ? 17'(-wide) : 17'(wide);
  assign over = mag > {1'b0, lim};
  assign reach = mag >= {1'b0, lim};
endmodule : csf_mag_cmp
`default_nettype wire

// file: core/csf_sync.sv
// two-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
`default_nettype none
module csf_sync #(
  parameter int W = 3
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  genvar i;
  for (i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        meta[i] <= 1'b0;
        q[i] <= 1'b0;
      end else begin
        meta[i] <= d[i];
        q[i] <= meta[i];
      end
    end
  end
endmodule : csf_sync
`default_nettype wire

// file: core/csf_top.sv
// status flag generator for the rotary cutter and feeding roll controller
//
// Contract
// - ready only after init and good self-test
// - cutter alarm when position error beyond limit
// - home high inside home window only
// - error flag follows detected operational error
// - homed set by homing, cleared by jog/disable
// - auto held while run, drops after cut standstill
// - virtual cut pulse at cut position, ends sync
// - missing mark after configured sheets without mark
// - learned flag after successful mark teach
// - mark window flag, always high when disabled
// - master moving above master standstill threshold
// - virtual master moving above its threshold
// - reverse flag by distance, cleared forward or clear
// - cutter correction saturation at maximum
// - thickness window per mode and positions
// - waste cut outside tolerance or test cut
// - feeder alarm when error beyond limit
// - feeder correction saturation at maximum
// - dancer alarm above dancer limit
// - dancer correction saturation at maximum
// - routed hardware output mirrors selected flag
// - all flags readable over the register port
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "csf_defines.svh"
module csf_top
  import csf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire csf_state_t st,
  input wire logic run_pin,
  input wire logic enable_pin,
  input wire logic clear_pin,
  input wire logic [`CSF_AW-1:0] addr,
  input wire logic [`CSF_DW-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [`CSF_DW-1:0] rdata,
  output logic [31:0] flags,
  output logic [`CSF_NOUT-1:0] hw_out
);
  logic rst_meta;
  logic rst_n;
  logic [`CSF_DW-1:0] cfg [1:20];
  logic [2:0] pin_s;
  logic ready;
  logic homed;
  logic vcut;
  logic no_mark;
  logic learned;
  logic rev;
  logic waste;
  logic [15:0] miss_cnt;
  logic [15:0] rev_dist;
  logic [15:0] knife_q;
  csf_auto_t auto_st;
  csf_auto_t next_auto;

  function automatic logic in_win(input logic [15:0] p, input logic [15:0] lo,
                                  input logic [15:0] hi);
    // a window with lo above hi wraps through zero
    if (lo <= hi) begin
      in_win = (p >= lo) && (p <= hi);
    end else begin
      in_win = (p >= lo) || (p <= hi);
    end
  endfunction : in_win

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  csf_sync #(.W(3)) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .d({clear_pin, enable_pin, run_pin}),
    .q(pin_s)
  );
  wire logic run_s = pin_s[0];
  wire logic en_s = pin_s[1];
  wire logic clr_s = pin_s[2];

  // register port
  wire logic cfg_hit = (addr != `CSF_R_STATUS) && (addr < `CSF_NREG);
  wire logic [`CSF_DW-1:0] rd_val = (addr == `CSF_R_STATUS) ? flags :
                                    cfg_hit ? cfg[addr] : `CSF_RST_VAL;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 1; i <= 20; i++) begin
        cfg[i] <= `CSF_RST_VAL;
      end
    end else if (wr && cfg_hit) begin
      cfg[addr] <= wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= `CSF_RST_VAL;
    end else if (rd) begin
      rdata <= rd_val;
    end
  end

  wire logic [15:0] cut_lim = cfg[`CSF_R_CUT_LIM][15:0];
  wire logic [15:0] feed_lim = cfg[`CSF_R_FEED_LIM][15:0];
  wire logic [15:0] dan_lim = cfg[`CSF_R_DAN_LIM][15:0];
  wire logic [15:0] rev_lim = cfg[`CSF_R_REV_LIM][15:0];
  wire logic [15:0] miss_lim = cfg[`CSF_R_MISS_LIM][15:0];
  wire logic [15:0] cut_pos = cfg[`CSF_R_CUT_POS][15:0];
  wire logic [31:0] cfg_w = cfg[`CSF_R_CFG];
  wire logic mark_en = cfg_w[`CSF_CFG_MARK_EN];
  wire logic [1:0] thk_mode = cfg_w[`CSF_CFG_THK_LSB +: 2];

  // magnitude comparators, one per signed quantity
  logic signed [15:0] cmp_val [0:`CSF_NCMP-1];
  logic [15:0] cmp_lim [0:`CSF_NCMP-1];
  logic [`CSF_NCMP-1:0] cmp_over;
  logic [`CSF_NCMP-1:0] cmp_reach;
  assign cmp_val[0] = st.cut_err;
  assign cmp_val[1] = st.feed_err;
  assign cmp_val[2] = st.cut_corr;
  assign cmp_val[3] = st.feed_corr;
  assign cmp_val[4] = st.dan_corr;
  assign cmp_val[5] = st.len_dev;
  assign cmp_lim[0] = cut_lim;
  assign cmp_lim[1] = feed_lim;
  assign cmp_lim[2] = cfg[`CSF_R_CUT_MAXC][15:0];
  assign cmp_lim[3] = cfg[`CSF_R_FEED_MAXC][15:0];
  assign cmp_lim[4] = cfg[`CSF_R_DAN_MAXC][15:0];
  assign cmp_lim[5] = cfg[`CSF_R_TOL][15:0];
  genvar c;
  for (c = 0; c < `CSF_NCMP; c++) begin : g_cmp
    csf_mag_cmp u_cmp (
      .val(cmp_val[c]),
      .lim(cmp_lim[c]),
      .over(cmp_over[c]),
      .reach(cmp_reach[c])
    );
  end

  wire logic home_in = in_win(st.knife_pos, cfg[`CSF_R_HOME_LO][15:0],
                              cfg[`CSF_R_HOME_HI][15:0]);
  wire logic mark_in = in_win(st.knife_pos, cfg[`CSF_R_MARK_LO][15:0],
                              cfg[`CSF_R_MARK_HI][15:0]);
  wire logic thk_in = in_win(st.knife_pos, cfg[`CSF_R_THK_LO][15:0],
                             cfg[`CSF_R_THK_HI][15:0]);
  wire logic thk_flag = (thk_mode == `CSF_THK_IN) ? thk_in :
                        (thk_mode == `CSF_THK_OUT) ? !thk_in : 1'b0;
  wire logic cut_hit = (st.knife_pos == cut_pos) && (knife_q != cut_pos);
  wire logic home_lost = st.jog_active || !en_s;
  wire logic [15:0] miss_nxt = (miss_cnt == 16'hffff) ? miss_cnt : miss_cnt + 16'h1;
  wire logic back = st.mst_step && st.mst_back;
  wire logic fwd = st.mst_step && !st.mst_back;

  // automatic operation
  always_comb begin
    next_auto = auto_st;
    case (auto_st)
      CSF_IDLE: begin
        if (run_s) begin
          next_auto = CSF_RUN;
        end
      end
      CSF_RUN: begin
        if (!run_s) begin
          next_auto = CSF_STOPPING;
        end
      end
      CSF_STOPPING: begin
        if (run_s) begin
          next_auto = CSF_RUN;
        end else if (!st.cut_busy && st.roll_still) begin
          next_auto = CSF_IDLE;
        end
      end
      default: begin
        next_auto = CSF_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      auto_st <= CSF_IDLE;
      knife_q <= 16'h0;
    end else begin
      auto_st <= next_auto;
      knife_q <= st.knife_pos;
    end
  end

  // sticky flags; a set in the same cycle as its clear wins
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ready <= 1'b0;
      homed <= 1'b0;
      learned <= 1'b0;
      vcut <= 1'b0;
      waste <= 1'b0;
    end else begin
      if (st.init_done && st.selftest_ok) begin
        ready <= 1'b1;
      end
      if (st.homing_fin) begin
        homed <= 1'b1;
      end else if (home_lost) begin
        homed <= 1'b0;
      end
      if (st.teach_ok) begin
        learned <= 1'b1;
      end
      if (cut_hit) begin
        vcut <= 1'b1;
      end else if (st.sync_end) begin
        vcut <= 1'b0;
      end
      if (st.cut_done) begin
        waste <= st.test_cut || cmp_over[5];
      end
    end
  end

  // missing printmark: sheets counted since the last accepted mark
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      miss_cnt <= 16'h0;
      no_mark <= 1'b0;
    end else if (st.mark_seen) begin
      miss_cnt <= 16'h0;
      no_mark <= 1'b0;
    end else if (st.sheet_end) begin
      miss_cnt <= miss_nxt;
      if (miss_lim != 16'h0 && miss_nxt >= miss_lim) begin
        no_mark <= 1'b1;
      end
    end
  end

  // reverse travel, distance counted in master steps
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rev_dist <= 16'h0;
      rev <= 1'b0;
    end else begin
      if (clr_s) begin
        rev_dist <= 16'h0;
      end else if (back && rev_dist != 16'hffff) begin
        rev_dist <= rev_dist + 16'h1;
      end else if (fwd && rev_dist != 16'h0) begin
        rev_dist <= rev_dist - 16'h1;
      end
      // set wins over clear; the zeroed count drops the flag one cycle later
      if (rev_dist > rev_lim) begin
        rev <= 1'b1;
      end else if (clr_s || rev_dist == 16'h0) begin
        rev <= 1'b0;
      end
    end
  end

  // flag vector; slots not listed stay low
  logic [31:0] next_flags;
  always_comb begin
    next_flags = 32'h0;
    next_flags[`CSF_F_READY] = ready;
    next_flags[`CSF_F_ALM_CUT] = cmp_over[0];
    next_flags[`CSF_F_HOME] = home_in;
    next_flags[`CSF_F_ERROR] = st.op_error;
    next_flags[`CSF_F_HOMED] = homed;
    next_flags[`CSF_F_AUTO] = (auto_st != CSF_IDLE);
    next_flags[`CSF_F_VCUT] = vcut;
    next_flags[`CSF_F_NO_MARK] = no_mark;
    next_flags[`CSF_F_LEARNED] = learned;
    next_flags[`CSF_F_MARK_WIN] = !mark_en || mark_in;
    next_flags[`CSF_F_MST_MOV] = st.mst_speed > cfg[`CSF_R_MZERO][15:0];
    next_flags[`CSF_F_VM_MOV] = st.vm_freq > cfg[`CSF_R_VZERO][15:0];
    next_flags[`CSF_F_REV] = rev;
    next_flags[`CSF_F_SAT_CUT] = cmp_reach[2];
    next_flags[`CSF_F_THK] = thk_flag;
    next_flags[`CSF_F_WASTE] = waste;
    next_flags[`CSF_F_ALM_FEED] = cmp_over[1];
    next_flags[`CSF_F_SAT_FEED] = cmp_reach[3];
    next_flags[`CSF_F_DAN_ALM] = st.dan_val > dan_lim;
    next_flags[`CSF_F_SAT_DAN] = cmp_reach[4];
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags <= 32'h0;
    end else begin
      flags <= next_flags;
    end
  end

  // hardware outputs, each routed from one selectable flag
  wire logic [31:0] sel_w = cfg[`CSF_R_OUT_SEL];
  genvar k;
  for (k = 0; k < `CSF_NOUT; k++) begin : g_out
    wire logic [`CSF_SEL_W-1:0] sel = sel_w[k*`CSF_SEL_W +: `CSF_SEL_W];
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        hw_out[k] <= 1'b0;
      end else begin
        hw_out[k] <= flags[sel];
      end
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  ready_gate_a: assert property (
    $rose(flags[`CSF_F_READY]) |-> $past(st.init_done && st.selftest_ok, 2))
    else $error("ready rose without init and self-test");
  cut_alarm_a: assert property (
    rst_n && cmp_over[0] |=> flags[`CSF_F_ALM_CUT])
    else $error("cutter alarm missing");
  home_win_a: assert property (
    rst_n |=> flags[`CSF_F_HOME] == $past(home_in))
    else $error("home flag does not follow window");
  error_flag_a: assert property (
    rst_n && st.op_error |=> flags[`CSF_F_ERROR])
    else $error("error flag missing");
  homed_clear_a: assert property (
    home_lost && !st.homing_fin |=> ##1 !flags[`CSF_F_HOMED])
    else $error("homed flag kept after jog or disable");
  auto_drop_a: assert property (
    $fell(flags[`CSF_F_AUTO]) |-> $past(!st.cut_busy && st.roll_still, 2))
    else $error("auto dropped before cut standstill");
  vcut_end_a: assert property (
    st.sync_end && !cut_hit |=> ##1 !flags[`CSF_F_VCUT])
    else $error("virtual cut pulse not ended");
  rev_clear_a: assert property (
    clr_s |=> ##2 !flags[`CSF_F_REV])
    else $error("reverse flag not cleared");
  unused_low_a: assert property (
    flags[21:17] == 5'h0 && flags[31:26] == 6'h0 && !flags[0])
    else $error("unused flag slot high");
  route_out_a: assert property (
    rst_n |=> hw_out[0] == $past(flags[g_out[0].sel]))
    else $error("hardware output does not mirror flag");
  status_read_a: assert property (
    rd && addr == `CSF_R_STATUS |=> rdata == $past(flags))
    else $error("status read mismatch");
endmodule : csf_top
`default_nettype wire

// file: shared/csf_defines.svh
// register indices, field positions and reset values of the cutter status flags
`ifndef CSF_DEFINES_SVH
`define CSF_DEFINES_SVH
`define CSF_AW 5
`define CSF_DW 32
`define CSF_VW 16
`define CSF_NREG 5'd21
`define CSF_R_STATUS 5'd0
`define CSF_R_CUT_LIM 5'd1
`define CSF_R_FEED_LIM 5'd2
`define CSF_R_DAN_LIM 5'd3
`define CSF_R_CUT_MAXC 5'd4
`define CSF_R_FEED_MAXC 5'd5
`define CSF_R_DAN_MAXC 5'd6
`define CSF_R_MZERO 5'd7
`define CSF_R_VZERO 5'd8
`define CSF_R_REV_LIM 5'd9
`define CSF_R_HOME_LO 5'd10
`define CSF_R_HOME_HI 5'd11
`define CSF_R_CUT_POS 5'd12
`define CSF_R_MARK_LO 5'd13
`define CSF_R_MARK_HI 5'd14
`define CSF_R_THK_LO 5'd15
`define CSF_R_THK_HI 5'd16
`define CSF_R_CFG 5'd17
`define CSF_R_MISS_LIM 5'd18
`define CSF_R_TOL 5'd19
`define CSF_R_OUT_SEL 5'd20
`define CSF_RST_VAL 32'h0
`define CSF_CFG_MARK_EN 0
`define CSF_CFG_THK_LSB 1
`define CSF_THK_OFF 2'h0
`define CSF_THK_IN 2'h1
`define CSF_THK_OUT 2'h2
`define CSF_SEL_W 5
`define CSF_NOUT 4
`define CSF_F_READY 1
`define CSF_F_ALM_CUT 2
`define CSF_F_HOME 3
`define CSF_F_ERROR 4
`define CSF_F_HOMED 5
`define CSF_F_AUTO 6
`define CSF_F_VCUT 7
`define CSF_F_NO_MARK 8
`define CSF_F_LEARNED 9
`define CSF_F_MARK_WIN 10
`define CSF_F_MST_MOV 11
`define CSF_F_VM_MOV 12
`define CSF_F_REV 13
`define CSF_F_SAT_CUT 14
`define CSF_F_THK 15
`define CSF_F_WASTE 16
`define CSF_F_ALM_FEED 22
`define CSF_F_SAT_FEED 23
`define CSF_F_DAN_ALM 24
`define CSF_F_SAT_DAN 25
`define CSF_NCMP 6
`endif

// file: shared/csf_pkg.sv
// types shared by the cutter status flag design
`include "csf_defines.svh"
package csf_pkg;
  typedef struct packed {
    logic init_done;
    logic selftest_ok;
    logic op_error;
    logic homing_fin;
    logic jog_active;
    logic sync_end;
    logic cut_done;
    logic test_cut;
    logic sheet_end;
    logic mark_seen;
    logic teach_ok;
    logic mst_step;
    logic mst_back;
    logic cut_busy;
    logic roll_still;
    logic signed [`CSF_VW-1:0] cut_err;
    logic signed [`CSF_VW-1:0] feed_err;
    logic signed [`CSF_VW-1:0] cut_corr;
    logic signed [`CSF_VW-1:0] feed_corr;
    logic signed [`CSF_VW-1:0] dan_corr;
    logic signed [`CSF_VW-1:0] len_dev;
    logic [`CSF_VW-1:0] knife_pos;
    logic [`CSF_VW-1:0] mst_speed;
    logic [`CSF_VW-1:0] vm_freq;
    logic [`CSF_VW-1:0] dan_val;
  } csf_state_t;
  typedef enum logic [1:0] {
    CSF_IDLE = 2'h0,
    CSF_RUN = 2'h1,
    CSF_STOPPING = 2'h3
  } csf_auto_t;
endpackage : csf_pkg
